// ==== core/port_a_pins.sv ====
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module port_a_pins #(
   parameter int unsigned PORT_WIDTH = 8,
   parameter int unsigned CYCLE_DIVIDE = port_a_pkg::CYCLE_CLOCK_DIVIDE
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [PORT_WIDTH-1:0] pad_in,
   output logic [PORT_WIDTH-1:0] pad_out,
   output logic [PORT_WIDTH-1:0] pad_oe,
   input wire port_a_pkg::osc_mode_type osc_mode,
   input wire logic comparator_one_result,
   input wire logic comparator_two_result,
   output logic timer_zero_clock_in,
   output logic slave_select_in,
   output logic [4:0] analog_channel_enable,
   output logic comparators_enabled,
   output logic reference_voltage_out
);

   // ************************************************************
   // Types and checks
   // ************************************************************
   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] direction;
      logic [7:0] converter_cfg;
      logic [5:0] comparator_cfg;
      logic [7:0] reference_cfg;
      logic [7:0] read_data;
   } port_state_type;

   // One flag per mapped register
   typedef struct packed {
      logic pin_level_port;
      logic output_latch;
      logic pin_direction;
      logic converter_pin_config;
      logic comparator_control;
      logic comparator_reference_control;
   } reg_select_type;

   generate
      if (PORT_WIDTH != 8) begin : g_bad_width
         $error("port width must be 8");
      end
      if (CYCLE_DIVIDE < 2) begin : g_bad_divide
         $error("cycle clock divide must be at least 2");
      end
      // Channel four must not wrap below zero
      if (port_a_pkg::ANALOG_PIN_SELECT_LIMIT < 4'h4) begin : g_bad_limit
         $error("analog select limit leaves no room for five channels");
      end
   endgenerate

   // ************************************************************
   // Decode functions
   // ************************************************************
   // Converter channel n is analog while the select field is at or below the limit minus n
   function automatic logic channel_is_analog(input logic [3:0] pin_select, input logic [3:0] channel);
      logic [3:0] limit;
      limit = port_a_pkg::ANALOG_PIN_SELECT_LIMIT - channel;
      return pin_select <= limit;
   endfunction : channel_is_analog

   function automatic logic bit6_is_port(input port_a_pkg::osc_mode_type mode);
      logic hit;
      hit = 1'b0;
      case (mode)
         port_a_pkg::rc_osc_with_port_pin,
         port_a_pkg::internal_osc_with_port_pin,
         port_a_pkg::external_clock_with_port_pin: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction : bit6_is_port

   function automatic logic bit6_is_clock_out(input port_a_pkg::osc_mode_type mode);
      logic hit;
      hit = 1'b0;
      case (mode)
         port_a_pkg::rc_osc_with_clock_out,
         port_a_pkg::internal_osc_with_clock_out,
         port_a_pkg::external_clock_with_clock_out: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction : bit6_is_clock_out

   function automatic logic bit7_is_port(input port_a_pkg::osc_mode_type mode);
      return (mode == port_a_pkg::internal_osc_with_port_pin) ||
             (mode == port_a_pkg::internal_osc_with_clock_out);
   endfunction : bit7_is_port

   // Address decode shared by the write and read paths
   function automatic reg_select_type decode_reg(input logic [2:0] addr);
      reg_select_type sel;
      sel = '0;
      if (addr == port_a_pkg::OFS_PIN_LEVEL_PORT) begin
         sel.pin_level_port = 1'b1;
      end else if (addr == port_a_pkg::OFS_OUTPUT_LATCH) begin
         sel.output_latch = 1'b1;
      end else if (addr == port_a_pkg::OFS_PIN_DIRECTION) begin
         sel.pin_direction = 1'b1;
      end else if (addr == port_a_pkg::OFS_CONVERTER_PIN_CONFIG) begin
         sel.converter_pin_config = 1'b1;
      end else if (addr == port_a_pkg::OFS_COMPARATOR_CONTROL) begin
         sel.comparator_control = 1'b1;
      end else if (addr == port_a_pkg::OFS_COMPARATOR_REFERENCE_CONTROL) begin
         sel.comparator_reference_control = 1'b1;
      end
      return sel;
   endfunction : decode_reg

   // Values held while reset is applied
   function automatic port_state_type reset_state();
      port_state_type s;
      s.latch = port_a_pkg::RST_OUTPUT_LATCH;
      s.direction = port_a_pkg::RST_PIN_DIRECTION;
      s.converter_cfg = port_a_pkg::RST_CONVERTER_PIN_CONFIG;
      s.comparator_cfg = port_a_pkg::RST_COMPARATOR_CONTROL;
      s.reference_cfg = port_a_pkg::RST_COMPARATOR_REFERENCE_CONTROL;
      s.read_data = port_a_pkg::RST_READ_DATA;
      return s;
   endfunction : reset_state

   // ************************************************************
   // State
   // ************************************************************
   port_state_type state_q;
   port_state_type state_d;

   logic cycle_clock;
   logic [7:0] port_pin;
   logic [7:0] pin_level;
   logic [7:0] alt_select;
   logic [7:0] alt_value;
   logic [7:0] force_drive;
   logic [7:0] drive_off;
   logic [7:0] input_off;
   logic [4:0] chan_analog;
   logic comparator_on;
   logic comparator_routed;
   logic reference_pin;
   logic bit2_analog;
   logic [7:0] port_read;
   reg_select_type wr_sel;
   reg_select_type rd_sel;
   logic [7:0] read_value;

   cycle_clock_divider #(
      .DIVIDE(CYCLE_DIVIDE)
   ) u_cycle_clock (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cycle_clock(cycle_clock)
   );

   // ************************************************************
   // Pin function selection
   // ************************************************************
   always_comb begin
      for (int n = 0; n < 5; n++) begin
         chan_analog[n] = channel_is_analog(state_q.converter_cfg[3:0], 4'(n));
      end
      comparator_on = state_q.comparator_cfg[2:0] != port_a_pkg::COMPARATOR_MODE_OFF;
      comparator_routed = state_q.comparator_cfg[2:0] == port_a_pkg::COMPARATOR_MODE_OUTPUTS;
      reference_pin = state_q.reference_cfg[port_a_pkg::POS_REFERENCE_ENABLE] &
                      state_q.reference_cfg[port_a_pkg::POS_REFERENCE_OUTPUT_ENABLE];
      bit2_analog = chan_analog[2] | comparator_on |
                    state_q.converter_cfg[port_a_pkg::POS_REFERENCE_SELECT_LOW];
      port_pin = 8'h3f;
      port_pin[6] = bit6_is_port(osc_mode);
      port_pin[7] = bit7_is_port(osc_mode);

      alt_select = 8'h00;
      alt_value = 8'h00;
      force_drive = 8'h00;
      drive_off = ~port_pin;
      input_off = ~port_pin;

      // Analog selection only blocks the digital input, never the driver
      input_off[0] = chan_analog[0] | comparator_on;
      input_off[1] = chan_analog[1] | comparator_on;
      input_off[2] = bit2_analog | reference_pin;
      input_off[3] = chan_analog[3] | comparator_on |
                     state_q.converter_cfg[port_a_pkg::POS_REFERENCE_SELECT_HIGH];
      input_off[4] = 1'b0;
      input_off[5] = chan_analog[4];

      // Reference output owns bit 2 whatever the direction
      drive_off[2] = reference_pin;
      input_off[2] = input_off[2] | reference_pin;

      // Comparator results take priority over the latch
      alt_select[4] = comparator_routed;
      alt_value[4] = comparator_one_result;
      alt_select[5] = comparator_routed;
      alt_value[5] = comparator_two_result;

      // Quarter-rate cycle clock drives bit 6 regardless of direction
      if (bit6_is_clock_out(osc_mode)) begin
         alt_select[6] = 1'b1;
         alt_value[6] = cycle_clock;
         force_drive[6] = 1'b1;
      end
   end

   // ************************************************************
   // Pin cells
   // ************************************************************
   generate
      for (genvar i = 0; i < 8; i++) begin : g_pin
         port_pin_cell u_cell (
            .direction(state_q.direction[i]),
            .latch(state_q.latch[i]),
            .alt_select(alt_select[i]),
            .alt_value(alt_value[i]),
            .force_drive(force_drive[i]),
            .drive_off(drive_off[i]),
            .input_off(input_off[i]),
            .pad_in(pad_in[i]),
            .pad_out(pad_out[i]),
            .pad_oe(pad_oe[i]),
            .level(pin_level[i])
         );
      end
   endgenerate

   // ************************************************************
   // Peripheral inputs
   // ************************************************************
   always_comb begin
      timer_zero_clock_in = pad_in[4];
      slave_select_in = pad_in[5] & state_q.direction[5];
      analog_channel_enable = chan_analog;
      comparators_enabled = comparator_on;
      reference_voltage_out = reference_pin;
      port_read = pin_level & port_pin;
   end

   // ************************************************************
   // Register select
   // ************************************************************
   // Strobe-qualified selects; an unmapped offset selects nothing
   always_comb begin
      wr_sel = '0;
      rd_sel = '0;
      if (reg_wr) begin
         wr_sel = decode_reg(reg_addr);
      end
      if (reg_rd) begin
         rd_sel = decode_reg(reg_addr);
      end
   end

   // ************************************************************
   // Read-back
   // ************************************************************
   always_comb begin
      if (rd_sel.pin_level_port) begin
         read_value = port_read;
      end else if (rd_sel.output_latch) begin
         read_value = state_q.latch & port_pin;
      end else if (rd_sel.pin_direction) begin
         read_value = state_q.direction & port_pin;
      end else if (rd_sel.converter_pin_config) begin
         read_value = state_q.converter_cfg;
      end else if (rd_sel.comparator_control) begin
         read_value = {comparator_two_result, comparator_one_result, state_q.comparator_cfg};
      end else if (rd_sel.comparator_reference_control) begin
         read_value = state_q.reference_cfg;
      end else begin
         read_value = 8'h00;
      end
   end

   // ************************************************************
   // Register update
   // ************************************************************
   always_comb begin
      state_d = state_q;
      if (wr_sel.pin_level_port) begin
         state_d.latch = reg_wdata;
      end else if (wr_sel.output_latch) begin
         state_d.latch = reg_wdata;
      end else if (wr_sel.pin_direction) begin
         state_d.direction = reg_wdata;
      end else if (wr_sel.converter_pin_config) begin
         state_d.converter_cfg = reg_wdata & port_a_pkg::MASK_CONVERTER_PIN_CONFIG;
      end else if (wr_sel.comparator_control) begin
         state_d.comparator_cfg = reg_wdata[5:0];
      end else if (wr_sel.comparator_reference_control) begin
         state_d.reference_cfg = reg_wdata;
      end
      // Read data stand one cycle, then fall back to zero
      state_d.read_data = read_value;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= reset_state();
      end else begin
         state_q <= state_d;
      end
   end

   assign reg_rdata = state_q.read_data;

endmodule : port_a_pins

`default_nettype wire

// ==== core/port_a_pkg.sv ====
package port_a_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [2:0] OFS_PIN_LEVEL_PORT = 3'h0;
   localparam logic [2:0] OFS_OUTPUT_LATCH = 3'h1;
   localparam logic [2:0] OFS_PIN_DIRECTION = 3'h2;
   localparam logic [2:0] OFS_CONVERTER_PIN_CONFIG = 3'h3;
   localparam logic [2:0] OFS_COMPARATOR_CONTROL = 3'h4;
   localparam logic [2:0] OFS_COMPARATOR_REFERENCE_CONTROL = 3'h5;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
   localparam logic [7:0] RST_PIN_DIRECTION = 8'hff;
   localparam logic [7:0] RST_CONVERTER_PIN_CONFIG = 8'h00;
   localparam logic [5:0] RST_COMPARATOR_CONTROL = 6'h07;
   localparam logic [7:0] RST_COMPARATOR_REFERENCE_CONTROL = 8'h00;
   localparam logic [7:0] RST_READ_DATA = 8'h00;

   // ************************************************************
   // Field positions and masks
   // ************************************************************
   localparam int unsigned POS_REFERENCE_SELECT_LOW = 4;
   localparam int unsigned POS_REFERENCE_SELECT_HIGH = 5;
   localparam logic [7:0] MASK_CONVERTER_PIN_CONFIG = 8'h3f;
   localparam int unsigned POS_COMPARATOR_TWO_RESULT = 7;
   localparam int unsigned POS_COMPARATOR_ONE_RESULT = 6;
   localparam int unsigned POS_REFERENCE_ENABLE = 7;
   localparam int unsigned POS_REFERENCE_OUTPUT_ENABLE = 6;
   localparam logic [3:0] ANALOG_PIN_SELECT_LIMIT = 4'he;
   localparam logic [2:0] COMPARATOR_MODE_OFF = 3'h7;
   localparam logic [2:0] COMPARATOR_MODE_OUTPUTS = 3'h3;

   // ************************************************************
   // Cycle clock
   // ************************************************************
   localparam int unsigned CYCLE_CLOCK_DIVIDE = 4;

   // ************************************************************
   // Oscillator configuration
   // ************************************************************
   typedef enum logic [3:0] {
      crystal_low_power = 4'h0,
      crystal_standard = 4'h1,
      crystal_high_speed = 4'h2,
      crystal_high_speed_pll = 4'h3,
      rc_osc_with_clock_out = 4'h4,
      rc_osc_with_port_pin = 4'h5,
      external_clock_with_clock_out = 4'h6,
      external_clock_with_port_pin = 4'h7,
      internal_osc_with_port_pin = 4'h8,
      internal_osc_with_clock_out = 4'h9
   } osc_mode_type;

endpackage : port_a_pkg

// ==== core/cycle_clock_divider.sv ====
`timescale 1ns/1ps
`default_nettype none

module cycle_clock_divider #(
   parameter int unsigned DIVIDE = port_a_pkg::CYCLE_CLOCK_DIVIDE
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   output logic cycle_clock
);

   localparam int unsigned CW = $clog2(DIVIDE);

   typedef struct packed {
      logic [CW-1:0] count;
      logic level;
   } div_state_type;

   div_state_type state_q;
   div_state_type state_d;

   generate
      if (DIVIDE < 2 || (DIVIDE & (DIVIDE - 1)) != 0) begin : g_bad_divide
         $error("cycle clock divide must be a power of two of at least 2");
      end
   endgenerate

   // Level is high in the upper half of each period
   always_comb begin
      state_d = state_q;
      state_d.count = state_q.count + CW'(1);
      state_d.level = state_d.count[CW-1];
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign cycle_clock = state_q.level;

endmodule : cycle_clock_divider

`default_nettype wire

// ==== core/port_pin_cell.sv ====
`timescale 1ns/1ps
`default_nettype none

module port_pin_cell (
   input wire logic direction,
   input wire logic latch,
   input wire logic alt_select,
   input wire logic alt_value,
   input wire logic force_drive,
   input wire logic drive_off,
   input wire logic input_off,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic level
);

   // Peripheral value replaces the latch; drive set by direction unless forced on or blocked by drive_off
   always_comb begin
      pad_out = alt_select ? alt_value : latch;
      pad_oe = force_drive | (~drive_off & ~direction);
      level = pad_in & ~input_off;
   end

endmodule : port_pin_cell

`default_nettype wire

// ==== test/port_a_pins_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Port checker
// ************************************************************
module port_a_pins_checker #(
   parameter int unsigned PORT_WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [PORT_WIDTH-1:0] pad_in,
   input wire logic [PORT_WIDTH-1:0] pad_out,
   input wire logic [PORT_WIDTH-1:0] pad_oe,
   input wire port_a_pkg::osc_mode_type osc_mode,
   input wire logic timer_zero_clock_in,
   input wire logic slave_select_in,
   input wire logic reference_voltage_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic [3:0] om;
   logic co;
   logic c6;
   logic [1:0] wlo;
   assign om = osc_mode;
   assign co = om inside {4'h4, 4'h6, 4'h9};
   assign c6 = pad_out[6];
   assign wlo = reg_wdata[1:0];
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_unmapped; reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_latch; reg_wr && reg_addr <= 3'h1 |=> pad_out[1:0] == $past(wlo); endproperty
   a_latch: assert property (p_latch) else $error("latch write not on pads");
   property p_ref; reference_voltage_out |-> !pad_oe[2]; endproperty
   a_ref: assert property (p_ref) else $error("bit 2 driven with reference out");
   property p_clk_oe; co |-> pad_oe[6]; endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("clock out not driven");
   property p_clk_div;
      co && $past(co) && $past(co, 2) && !$past(sys_rst) && !$past(sys_rst, 2) |-> c6 != $past(c6, 2);
   endproperty
   a_clk_div: assert property (p_clk_div) else $error("clock out not quarter rate");
   property p_osc7; !(om inside {4'h8, 4'h9}) |-> !pad_oe[7]; endproperty
   a_osc7: assert property (p_osc7) else $error("bit 7 driven in oscillator mode");
   property p_osc6; om < 4'h4 |-> !pad_oe[6]; endproperty
   a_osc6: assert property (p_osc6) else $error("bit 6 driven in oscillator mode");
   property p_dir_rd; reg_rd && reg_addr == 3'h2 && om < 4'h4 |=> reg_rdata[7:6] == 2'b00; endproperty
   a_dir_rd: assert property (p_dir_rd) else $error("bits 7:6 direction not zero");
   property p_timer; timer_zero_clock_in == pad_in[4]; endproperty
   a_timer: assert property (p_timer) else $error("timer clock not bit 4");
   property p_ss; slave_select_in |-> pad_in[5]; endproperty
   a_ss: assert property (p_ss) else $error("slave select without pin level");
   c_clk: cover property (co ##4 co);
   c_ref: cover property (reference_voltage_out);
   c_unmapped: cover property (reg_rd && reg_addr > 3'h5);
endmodule : port_a_pins_checker

bind port_a_pins port_a_pins_checker #(.PORT_WIDTH(PORT_WIDTH)) chk_i (.core_clk(core_clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .osc_mode(osc_mode),
   .timer_zero_clock_in(timer_zero_clock_in), .slave_select_in(slave_select_in),
   .reference_voltage_out(reference_voltage_out));
`default_nettype wire

// ==== test/port_a_pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// External pins
// ************************************************************
module port_a_pad_model (
   input wire logic core_clk,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] pad_in
);
   logic [7:0] wobble_q = 8'h00;
   always_ff @(posedge core_clk) begin
      wobble_q <= ~wobble_q;
   end
   // Floating pins flip every cycle
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & wobble_q);
endmodule : port_a_pad_model
`default_nettype wire

// ==== test/port_a_pins_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Testbench
// ************************************************************
module port_a_pins_tb_top;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, pad_in, pad_out, pad_oe, rd_v;
   logic [7:0] ext_en = 8'hff;
   logic [7:0] ext_val = 8'hff;
   port_a_pkg::osc_mode_type osc_mode = port_a_pkg::crystal_low_power;
   logic cmp1 = 1'b0;
   logic cmp2 = 1'b0;
   logic t0ck, ss_in, cmp_en, vref;
   logic [4:0] an_en;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;

   port_a_pins uut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .osc_mode(osc_mode), .comparator_one_result(cmp1), .comparator_two_result(cmp2),
      .timer_zero_clock_in(t0ck), .slave_select_in(ss_in), .analog_channel_enable(an_en),
      .comparators_enabled(cmp_en), .reference_voltage_out(vref));
   port_a_pad_model pads (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pad_in(pad_in));

   always #12.5 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic test_done;
      if (bad_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask : rd

   task automatic set_osc(input port_a_pkg::osc_mode_type m);
      @(posedge core_clk);
      osc_mode <= m;
   endtask : set_osc

   task automatic t_reset;
      rd(3'h2);
      chk("direction", rd_v, 8'h3f);
      rd(3'h0);
      chk("port", rd_v, 8'h10);
      rd(3'h3);
      chk("converter", rd_v, 8'h00);
      rd(3'h6);
      chk("unmapped6", rd_v, 8'h00);
      rd(3'h7);
      chk("unmapped7", rd_v, 8'h00);
      chk("channels", {3'h0, an_en}, 8'h1f);
      chk("cmp on", {7'h0, cmp_en}, 8'h00);
      chk("oe", pad_oe, 8'h00);
   endtask : t_reset

   task automatic t_latch;
      set_osc(port_a_pkg::internal_osc_with_port_pin);
      wr(3'h0, 8'ha5);
      rd(3'h1);
      chk("latch", rd_v, 8'ha5);
      wr(3'h1, 8'h3c);
      wr(3'h2, 8'h00);
      #1 chk("oe", pad_oe, 8'hff);
      chk("drive", pad_out, 8'h3c);
      rd(3'h1);
      chk("latch", rd_v, 8'h3c);
   endtask : t_latch

   task automatic t_input;
      wr(3'h2, 8'hff);
      wr(3'h3, 8'h0f);
      ext_val <= 8'h5a;
      rd(3'h0);
      chk("port", rd_v, 8'h5a);
      chk("channels", {3'h0, an_en}, 8'h00);
      wr(3'h3, 8'h00);
      rd(3'h0);
      chk("port", rd_v, 8'h50);
      set_osc(port_a_pkg::crystal_high_speed);
      rd(3'h0);
      chk("port", rd_v, 8'h10);
      rd(3'h2);
      chk("direction", rd_v, 8'h3f);
      wr(3'h2, 8'h00);
      #1 chk("oe", pad_oe & 8'hc0, 8'h00);
      set_osc(port_a_pkg::external_clock_with_port_pin);
      #1 chk("oe", pad_oe & 8'hc0, 8'h40);
   endtask : t_input

   task automatic t_comp;
      set_osc(port_a_pkg::internal_osc_with_port_pin);
      wr(3'h1, 8'h00);
      wr(3'h4, 8'h03);
      cmp1 <= 1'b1;
      #1 chk("cmp one", {6'h0, pad_out[5:4]}, 8'h01);
      chk("cmp on", {7'h0, cmp_en}, 8'h01);
      @(posedge core_clk);
      cmp1 <= 1'b0;
      cmp2 <= 1'b1;
      #1 chk("cmp two", {6'h0, pad_out[5:4]}, 8'h02);
      wr(3'h2, 8'hff);
      wr(3'h3, 8'h0f);
      ext_val <= 8'hff;
      rd(3'h0);
      chk("port", rd_v, 8'hf0);
      wr(3'h4, 8'h07);
      cmp2 <= 1'b0;
   endtask : t_comp

   task automatic t_ref;
      wr(3'h2, 8'h00);
      wr(3'h5, 8'hc0);
      #1 chk("ref", {6'h0, pad_oe[2], vref}, 8'h01);
      wr(3'h2, 8'hff);
      rd(3'h0);
      chk("port", rd_v, 8'hfb);
      wr(3'h5, 8'h00);
      wr(3'h3, 8'h1f);
      rd(3'h0);
      chk("port", rd_v, 8'hfb);
      wr(3'h3, 8'h0f);
      rd(3'h0);
      chk("port", rd_v, 8'hff);
   endtask : t_ref

   task automatic t_clkout;
      int h;
      h = 0;
      set_osc(port_a_pkg::rc_osc_with_clock_out);
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         #1 h += pad_out[6];
         chk("clk oe", {7'h0, pad_oe[6]}, 8'h01);
      end
      chk("clk highs", 8'(h), 8'h04);
      set_osc(port_a_pkg::internal_osc_with_clock_out);
      rd(3'h2);
      chk("direction", rd_v, 8'hbf);
      chk("clk oe", {7'h0, pad_oe[6]}, 8'h01);
   endtask : t_clkout

   task automatic t_slave;
      @(posedge core_clk);
      ext_val <= 8'h30;
      #1 chk("ss t0", {6'h0, ss_in, t0ck}, 8'h03);
      wr(3'h1, 8'h20);
      wr(3'h2, 8'hdf);
      #1 chk("ss t0", {6'h0, ss_in, t0ck}, 8'h01);
   endtask : t_slave

   initial begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_latch();
      t_input();
      t_comp();
      t_ref();
      t_clkout();
      t_slave();
      test_done();
   end
endmodule : port_a_pins_tb_top
`default_nettype wire
